// ==== hw/drtp_cfg.svh ====
/*
 * Constants of the dual reload timer: register word indices, field
 * positions, reset values and counter limits.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef DRTP_CFG_SVH
`define DRTP_CFG_SVH
// -----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// -----------------------------------------------------------------
`define DRTP_RLD1_H 6'h10
`define DRTP_RLD1_L 6'h11
`define DRTP_OUT_CTL 6'h12
`define DRTP_CSR_BASE 6'h13
`define DRTP_CSR_LAST 6'h16
`define DRTP_DUTY_BASE 6'h17
`define DRTP_DUTY_LAST 6'h1E
`define DRTP_CAP_H 6'h1F
`define DRTP_CAP_L 6'h20
`define DRTP_CSR2 6'h21
`define DRTP_FAULT 6'h22
`define DRTP_RLD2_H 6'h23
`define DRTP_RLD2_L 6'h24
`define DRTP_GUARD 6'h25
`define DRTP_CFG 6'h26
// -----------------------------------------------------------------
// Field positions, reset values, limits
// -----------------------------------------------------------------
`define DRTP_CAPF_BIT 6
`define DRTP_CSR2_RST 8'h03
`define DRTP_CNT_MAX 12'hFFF
`define DRTP_SRC_LITE 2'h1
`define DRTP_SRC_CPU 2'h2
`define DRTP_GUARD_W 7
`endif

// ==== hw/drtp_pkg.sv ====
/*
 * Types of the dual reload timer: bus answer states and the state record.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package drtp_pkg;
  // -----------------------------------------------------------------
  // Bus answer states, one-hot
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    DRTP_BUS_IDLE = 2'b01,
    DRTP_BUS_ACK = 2'b10
  } drtp_bus_t;

  // -----------------------------------------------------------------
  // Whole state of the timer top
  // -----------------------------------------------------------------
  typedef struct packed {
    drtp_bus_t bus;
    logic [31:0] rdata;
    logic cap_seen;
    logic [11:0] cnt1;
    logic [11:0] cnt2;
    logic [11:0] reload1;
    logic [11:0] reload2;
    logic [3:0][11:0] duty_pre;
    logic [3:0][11:0] duty_act;
    logic [3:0] oe;
    logic [3:0] pol_pre;
    logic [3:0] pol_act;
    logic [3:0] cmp_flag;
    logic [3:0] raw;
    logic [3:0] pwm;
    logic [3:0] pattern;
    logic brk;
    logic pin_en;
    logic cap_src;
    logic wrap_ie;
    logic wrap_flag;
    logic run2;
    logic copy2;
    logic copy1;
    logic [1:0] src;
    logic guard_en;
    logic [6:0] guard_len;
    logic [11:0] capture;
    logic cap_flag;
    logic cap_prev;
    logic irq;
  } drtp_state_t;
endpackage

// ==== hw/drtp_guard_if.sv ====
/*
 * Link between the timer top and its guard interval generator.
 * Assumes both ends run on the same clock.
 */
interface drtp_guard_if #(parameter int GUARD_W = 7);
  logic raw;
  logic tick;
  logic en;
  logic [GUARD_W-1:0] len;
  logic hi;
  logic lo;
  modport guard(input raw, input tick, input en, input len, output hi, output lo);
  modport timer(output raw, output tick, output en, output len, input hi, input lo);
endinterface

// ==== hw/drtp_sync.sv ====
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes pins idle high; the first stage feeds only the second.
 */
module drtp_sync #(
  parameter int W = 3
) (
  input wire logic clock_in, // System clock
  input wire logic rst_in, // Synchronous reset, high
  input wire logic [W-1:0] async_in, // Raw pin levels
  output logic [W-1:0] sync_out // Settled pin levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } drtp_sync_t;
  drtp_sync_t q;
  drtp_sync_t d;

  if (W < 1) begin : g_chk
    $error("drtp_sync needs W of at least one");
  end

  // Shift chain
  always_comb begin
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (rst_in) q <= '1;
    else q <= d;
  end

  assign sync_out = q.s2;
endmodule // drtp_sync

// ==== hw/drtp_guard.sv ====
/*
 * Guard interval generator for the complementary pair PWM0/PWM1.
 * Assumes the tick is the main counter clock enable of the timer top.
 */
module drtp_guard #(
  parameter int GUARD_W = 7
) (
  input wire logic clock_in, // System clock
  input wire logic rst_in, // Synchronous reset, high
  drtp_guard_if.guard gi // Raw waveform in, guarded pair out
);
  typedef struct packed {
    logic [GUARD_W-1:0] cnt;
    logic prev;
    logic hi;
    logic lo;
  } drtp_guard_t;
  drtp_guard_t q;
  drtp_guard_t d;

  if (GUARD_W < 1 || GUARD_W > 16) begin : g_chk
    $error("drtp_guard width out of range");
  end

  // Both legs low for one cycle plus len counter ticks after every edge
  always_comb begin
    d = q;
    d.prev = gi.raw;
    if (gi.raw != q.prev) begin
      d.cnt = gi.len;
      d.hi = 1'b0;
      d.lo = 1'b0;
    end else if (q.cnt != '0) begin
      if (gi.tick) d.cnt = GUARD_W'(q.cnt - 1'b1);
    end else begin
      d.hi = gi.raw;
      d.lo = !gi.raw;
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (rst_in) q <= '0;
    else q <= d;
  end

  assign gi.hi = q.hi;
  assign gi.lo = q.lo;

  a_guard_gap: assert property (@(posedge clock_in) disable iff (rst_in)
    ($changed(gi.raw) && gi.len != '0) |=> !gi.hi && !gi.lo) else $error("no gap after edge");
  a_guard_count: assert property (@(posedge clock_in) disable iff (rst_in)
    (q.cnt != '0 && gi.tick && !$changed(gi.raw)) |=> q.cnt == $past(q.cnt) - 1'b1)
    else $error("guard count did not step");
endmodule // drtp_guard

// ==== hw/drtp_timer.sv ====
/*
 * Dual 12-bit reload timer with four PWM outputs, stop pattern,
 * capture and guard interval, as an Avalon-MM slave with waitrequest.
 * Assumes one 100 MHz clock, synchronous high reset, and a lite timer
 * tick that is a one-cycle pulse from logic on the same clock.
 */
// Summary of operation
// - Main counter overflow reloads main counter from reload value one.
// - Output enable bits reset to zero; one selects PWM on that pin.
// - Polarity bit one inverts the channel waveform; resets to zero.
// - Compare flag sets on counter equal active duty; channel status read clears.
// - Break bit is writable, reset clear, set while enabled fault pin is low.
// - Fault pin enable bit, reset clear, gates the fault pin.
// - During break all four outputs show the stop pattern.
// - Top two bits of fault and second status registers read zero.
// - Enabled channel duty value sets its PWM duty cycle.
// - Duty value is the compare operand against the upcounter.
// - Capture register resets clear, latches main counter on selected pin edge.
// - No new capture while capture flag stays set.
// - Capture source bit picks own pin or lite capture pin.
// - Second wrap interrupt enable gates the second wrap interrupt.
// - Second wrap flag sets on second counter wrap; status read clears.
// - Second counter runs when run bit set and then times channels 2, 3.
// - Copy enable two moves channels 2, 3 at second overflow, then clears.
// - Copy enable one moves channel 0, 1 preloads at main overflow (all four while second counter stopped), then clears.
// - Second counter overflow reloads from reload value two.
// - Guard enable inserts dead time between PWM0 and PWM1.
// - Dead time lasts one cycle plus guard length main counter ticks.
// - Count source 01 is lite tick, 10 every clock, else stopped.
`include "drtp_cfg.svh"

module drtp_timer #(
  parameter int DATA_W = 32
) (
  input wire logic clock_in, // System clock, 100 MHz
  input wire logic rst_in, // Synchronous reset, high
  input wire logic [5:0] avm_address_in, // Register word index
  input wire logic avm_read_in, // Read request
  input wire logic avm_write_in, // Write request
  input wire logic [31:0] avm_writedata_in, // Write data
  input wire logic [3:0] avm_byteenable_in, // Byte lanes
  output logic [31:0] avm_readdata_out, // Read data
  output logic avm_waitrequest_out, // Stall request
  input wire logic lite_tick_in, // Lite timer tick pulse
  input wire logic fault_pin_n_in, // Break pin, low active
  input wire logic timer_capture_pin_in, // Own capture pin
  input wire logic lite_capture_pin_in, // Lite capture pin
  output logic [3:0] pwm_out, // PWM pin levels
  output logic [3:0] pwm_enable_out, // PWM owns pin
  output logic second_wrap_irq_out // Second wrap interrupt
);
  localparam logic [7:0] CSR2_RST = `DRTP_CSR2_RST;

  drtp_pkg::drtp_state_t q;
  drtp_pkg::drtp_state_t d;
  logic [2:0] pins_s;
  logic tick;
  logic tick2;
  logic ovf1;
  logic second_wrap_flag;
  logic acc;
  logic take;
  logic sel;
  logic ttick;
  logic tovf;
  logic match;
  logic [11:0] tcnt;
  logic [1:0] c;
  logic [3:0] base;
  logic [7:0] wd;

  if (DATA_W != 32) begin : g_chk
    $error("drtp_timer serves a 32-bit bus only");
  end

  // -----------------------------------------------------------------
  // Address helpers
  // -----------------------------------------------------------------
  // Index lies in an inclusive span
  function automatic logic in_span(input logic [5:0] a, input logic [5:0] lo, input logic [5:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Channel of a duty register index
  function automatic logic [1:0] duty_ch(input logic [5:0] a);
    logic [5:0] off;
    off = a - `DRTP_DUTY_BASE;
    return off[2:1];
  endfunction

  // Channel of a channel status index
  function automatic logic [1:0] csr_ch(input logic [5:0] a);
    logic [5:0] off;
    off = a - `DRTP_CSR_BASE;
    return off[1:0];
  endfunction

  // Read value of one register
  function automatic logic [7:0] rd_byte(input drtp_pkg::drtp_state_t s, input logic [5:0] a);
    logic [1:0] k;
    rd_byte = 8'h00;
    k = 2'h0;
    if (in_span(a, `DRTP_DUTY_BASE, `DRTP_DUTY_LAST)) begin
      k = duty_ch(a);
      rd_byte = a[0] ? {4'h0, s.duty_pre[k][11:8]} : s.duty_pre[k][7:0];
    end else if (in_span(a, `DRTP_CSR_BASE, `DRTP_CSR_LAST)) begin
      k = csr_ch(a);
      rd_byte = {6'h00, s.pol_pre[k], s.cmp_flag[k]};
    end else begin
      case (a)
        `DRTP_RLD1_H: rd_byte = {4'h0, s.reload1[11:8]};
        `DRTP_RLD1_L: rd_byte = s.reload1[7:0];
        `DRTP_OUT_CTL: rd_byte = {1'b0, s.oe[3], 1'b0, s.oe[2], 1'b0, s.oe[1], 1'b0, s.oe[0]};
        `DRTP_CAP_H: rd_byte = {4'h0, s.capture[11:8]};
        `DRTP_CAP_L: rd_byte = s.capture[7:0];
        `DRTP_CSR2: rd_byte = {2'h0, s.cap_src, s.wrap_ie, s.wrap_flag, s.run2, s.copy2, s.copy1};
        `DRTP_FAULT: rd_byte = {2'h0, s.brk, s.pin_en, s.pattern};
        `DRTP_RLD2_H: rd_byte = {4'h0, s.reload2[11:8]};
        `DRTP_RLD2_L: rd_byte = s.reload2[7:0];
        `DRTP_GUARD: rd_byte = {s.guard_en, s.guard_len};
        `DRTP_CFG: rd_byte = {1'b0, s.cap_flag, 4'h0, s.src};
        default: rd_byte = 8'h00;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------
  // Pin synchronisers and guard generator
  // -----------------------------------------------------------------
  drtp_sync #(.W(3)) u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in({fault_pin_n_in, timer_capture_pin_in, lite_capture_pin_in}),
    .sync_out(pins_s)
  );

  drtp_guard_if #(.GUARD_W(`DRTP_GUARD_W)) g ();

  drtp_guard #(.GUARD_W(`DRTP_GUARD_W)) u_guard (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .gi(g)
  );

  // Guard generator follows channel 0 raw waveform
  assign g.raw = q.raw[0];
  assign g.tick = tick;
  assign g.en = q.guard_en;
  assign g.len = q.guard_len;

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    d = q;
    tick = (q.src == `DRTP_SRC_CPU) || ((q.src == `DRTP_SRC_LITE) && lite_tick_in);
    ovf1 = tick && (q.cnt1 == `DRTP_CNT_MAX);
    tick2 = tick && q.run2;
    second_wrap_flag = tick2 && (q.cnt2 == `DRTP_CNT_MAX);
    acc = avm_read_in || avm_write_in;
    take = acc && (q.bus == drtp_pkg::DRTP_BUS_ACK);
    wd = avm_writedata_in[7:0];
    sel = 1'b0;
    ttick = 1'b0;
    tovf = 1'b0;
    match = 1'b0;
    tcnt = q.cnt1;
    c = 2'h0;
    base = 4'h0;

    // Counters: reload on wrap, else count up
    if (tick) d.cnt1 = ovf1 ? q.reload1 : 12'(q.cnt1 + 12'h001);
    if (tick2) d.cnt2 = second_wrap_flag ? q.reload2 : 12'(q.cnt2 + 12'h001);

    // Bus: decode in first cycle, answer in second
    case (q.bus)
      drtp_pkg::DRTP_BUS_IDLE: begin
        if (acc) begin
          d.bus = drtp_pkg::DRTP_BUS_ACK;
          if (avm_read_in) begin
            d.rdata = {24'h000000, rd_byte(q, avm_address_in)};
            d.cap_seen = q.cap_flag;
          end
        end
      end
      drtp_pkg::DRTP_BUS_ACK: begin
        d.bus = drtp_pkg::DRTP_BUS_IDLE;
        if (avm_write_in && avm_byteenable_in[0]) begin
          if (in_span(avm_address_in, `DRTP_DUTY_BASE, `DRTP_DUTY_LAST)) begin
            c = duty_ch(avm_address_in);
            if (avm_address_in[0]) d.duty_pre[c][11:8] = wd[3:0];
            else d.duty_pre[c][7:0] = wd;
          end else if (in_span(avm_address_in, `DRTP_CSR_BASE, `DRTP_CSR_LAST)) begin
            c = csr_ch(avm_address_in);
            d.pol_pre[c] = wd[1];
          end else begin
            case (avm_address_in)
              `DRTP_RLD1_H: d.reload1[11:8] = wd[3:0];
              `DRTP_RLD1_L: d.reload1[7:0] = wd;
              `DRTP_OUT_CTL: d.oe = {wd[6], wd[4], wd[2], wd[0]};
              `DRTP_CSR2: begin
                d.cap_src = wd[5];
                d.wrap_ie = wd[4];
                d.run2 = wd[2];
                d.copy2 = wd[1];
                d.copy1 = wd[0];
              end
              `DRTP_FAULT: begin
                d.brk = wd[5];
                d.pin_en = wd[4];
                d.pattern = wd[3:0];
              end
              `DRTP_RLD2_H: d.reload2[11:8] = wd[3:0];
              `DRTP_RLD2_L: d.reload2[7:0] = wd;
              `DRTP_GUARD: begin
                d.guard_en = wd[7];
                d.guard_len = wd[6:0];
              end
              `DRTP_CFG: d.src = wd[1:0];
              default: d.src = q.src;
            endcase
          end
        end
        // Read side effects: clear only what the answer showed
        if (avm_read_in) begin
          if (in_span(avm_address_in, `DRTP_CSR_BASE, `DRTP_CSR_LAST)) begin
            c = csr_ch(avm_address_in);
            if (q.rdata[0]) d.cmp_flag[c] = 1'b0;
          end
          if (avm_address_in == `DRTP_CSR2 && q.rdata[3]) d.wrap_flag = 1'b0;
          if (in_span(avm_address_in, `DRTP_CAP_H, `DRTP_CAP_L) && q.cap_seen) d.cap_flag = 1'b0;
        end
      end
      default: d.bus = drtp_pkg::DRTP_BUS_IDLE;
    endcase

    // Channels: set at overflow, clear at duty match
    for (int i = 0; i < 4; i++) begin
      tcnt = (i >= 2 && q.run2) ? q.cnt2 : q.cnt1;
      ttick = (i >= 2 && q.run2) ? tick2 : tick;
      tovf = (i >= 2 && q.run2) ? second_wrap_flag : ovf1;
      match = ttick && (tcnt == q.duty_act[i]);
      if (match) d.cmp_flag[i] = 1'b1;
      if (tovf) d.raw[i] = 1'b1;
      else if (match) d.raw[i] = 1'b0;
    end

    // Preload copies at each counter's overflow
    if (ovf1 && q.copy1) begin
      d.copy1 = 1'b0;
      for (int i = 0; i < 4; i++) begin
        if (i < 2 || !q.run2) begin
          d.duty_act[i] = q.duty_pre[i];
          d.pol_act[i] = q.pol_pre[i];
        end
      end
    end
    if (second_wrap_flag && q.copy2) begin
      d.copy2 = 1'b0;
      d.duty_act[3:2] = q.duty_pre[3:2];
      d.pol_act[3:2] = q.pol_pre[3:2];
    end

    // Fault pin sets break after any software write
    if (q.pin_en && !pins_s[2]) d.brk = 1'b1;

    // Capture on either edge of the chosen pin
    sel = q.cap_src ? pins_s[0] : pins_s[1];
    d.cap_prev = sel;
    if ((sel != q.cap_prev) && !q.cap_flag) begin
      d.capture = q.cnt1;
      d.cap_flag = 1'b1;
    end

    // Second wrap flag and its interrupt
    if (second_wrap_flag) d.wrap_flag = 1'b1;
    d.irq = q.wrap_flag && q.wrap_ie;

    // Pin levels: guard pair, polarity, stop pattern
    base = {q.raw[3:2], q.guard_en ? {g.lo, g.hi} : q.raw[1:0]};
    d.pwm = q.brk ? q.pattern : (base ^ q.pol_act);
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      q <= '0;
      q.bus <= drtp_pkg::DRTP_BUS_IDLE;
      q.copy1 <= CSR2_RST[0];
      q.copy2 <= CSR2_RST[1];
      q.cap_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign avm_readdata_out = q.rdata;
  assign avm_waitrequest_out = acc && (q.bus != drtp_pkg::DRTP_BUS_ACK);
  assign pwm_out = q.pwm;
  assign pwm_enable_out = q.oe;
  assign second_wrap_irq_out = q.irq;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // First cycle of a read at a given index
  sequence s_read_start(logic [5:0] a);
    (q.bus == drtp_pkg::DRTP_BUS_IDLE) && avm_read_in && (avm_address_in == a);
  endsequence

  // Completed write at a given index
  sequence s_write_take(logic [5:0] a);
    take && avm_write_in && avm_byteenable_in[0] && (avm_address_in == a);
  endsequence

  a_reload_one: assert property (ovf1 |=> q.cnt1 == $past(q.reload1))
    else $error("main counter not reloaded");
  a_enable_write: assert property (s_write_take(`DRTP_OUT_CTL) |=>
    pwm_enable_out == {$past(avm_writedata_in[6]), $past(avm_writedata_in[4]),
    $past(avm_writedata_in[2]), $past(avm_writedata_in[0])}) else $error("enables not written");
  a_polarity_out: assert property (!q.brk |=>
    pwm_out[3] == ($past(q.raw[3]) ^ $past(q.pol_act[3]))) else $error("polarity wrong");
  a_compare_flag: assert property ((tick && q.cnt1 == q.duty_act[0]) |=> q.cmp_flag[0])
    else $error("compare flag not set");
  a_break_set: assert property ((q.pin_en && !pins_s[2]) |=> q.brk)
    else $error("break not set by pin");
  a_stop_pattern: assert property (q.brk |=> pwm_out == $past(q.pattern))
    else $error("stop pattern not shown");
  a_reserved_zero: assert property ((s_read_start(`DRTP_FAULT) or s_read_start(`DRTP_CSR2)) |=>
    q.rdata[7:6] == 2'h0) else $error("reserved bits read nonzero");
  a_capture_hold: assert property ((q.cap_flag ##1 q.cap_flag) |-> $stable(q.capture))
    else $error("capture changed while flag set");
  a_wrap_flag: assert property (second_wrap_flag |=> q.wrap_flag)
    else $error("wrap flag not set");
  a_copy_done: assert property ((ovf1 && q.copy1 && !take) |=>
    !q.copy1 && q.duty_act[0] == $past(q.duty_pre[0])) else $error("preload copy wrong");
  a_reload_two: assert property (second_wrap_flag |=> q.cnt2 == $past(q.reload2))
    else $error("second counter not reloaded");
endmodule // drtp_timer

// ==== sim/drtp_power_stage.sv ====
/*
 * Model of the external power stage on the PWM and fault pins.
 * Assumes the bench raises trip_in to pull the fault line low.
 */
module drtp_power_stage (
  input wire logic [3:0] pwm_in, // Gate levels
  input wire logic [3:0] pwm_enable_in, // Timer owns pin
  input wire logic trip_in, // Bench fault command
  output logic fault_pin_n_out, // Fault line, pulled up
  output logic overlap_out // PWM0 and PWM1 both on
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------
  // Fault line and shoot-through watch
  // --------------------------------------------------
  // Pull-up holds the line high unless tripped
  assign fault_pin_n_out = trip_in ? 1'b0 : 1'b1;
  // Both gates of the pair on at once
  assign overlap_out = (&pwm_in[1:0]) & (&pwm_enable_in[1:0]);
endmodule // drtp_power_stage

// ==== sim/tb_drtp_timer.sv ====
/*
 * Self-checking bench of the dual reload timer.
 * Assumes the timer answers bus requests and the power stage model.
 */
module tb_drtp_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic wait_req;
  logic tick = 1'b0;
  logic trip = 1'b0;
  logic cap_pin = 1'b1;
  logic lite_pin = 1'b1;
  logic fault_n;
  logic [3:0] pwm;
  logic [3:0] pwm_en;
  logic irq;
  logic overlap;
  int err_count = 0;
  int total_checks = 0;
  // --------------------------------------------------
  // Clock, design and partner
  // --------------------------------------------------
  // 100 MHz clock
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  drtp_timer u_dut (.clock_in(clock_in), .rst_in(rst_in), .avm_address_in(addr), .avm_read_in(rd),
    .avm_write_in(wr), .avm_writedata_in(wdata), .avm_byteenable_in(be), .avm_readdata_out(rdata),
    .avm_waitrequest_out(wait_req), .lite_tick_in(tick), .fault_pin_n_in(fault_n),
    .timer_capture_pin_in(cap_pin), .lite_capture_pin_in(lite_pin), .pwm_out(pwm),
    .pwm_enable_out(pwm_en), .second_wrap_irq_out(irq));
  drtp_power_stage u_stage (.pwm_in(pwm), .pwm_enable_in(pwm_en), .trip_in(trip),
    .fault_pin_n_out(fault_n), .overlap_out(overlap));
  // --------------------------------------------------
  // Shared tasks
  // --------------------------------------------------
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock_in);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    @(posedge clock_in);
    while (wait_req !== 1'b0 && n < 20) begin
      @(posedge clock_in);
      n++;
    end
    if (n == 20) err_count++;
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rreg(input logic [5:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, {4'h0, exp}, {4'h0, q});
  endtask
  task automatic do_reset;
    @(posedge clock_in);
    rst_in <= 1'b1;
    cap_pin <= 1'b1;
    lite_pin <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock_in);
      tick <= 1'b1;
      @(posedge clock_in);
      tick <= 1'b0;
    end
  endtask
  task automatic pin_edge(input logic lite);
    @(posedge clock_in);
    if (lite) lite_pin <= !lite_pin;
    else cap_pin <= !cap_pin;
    repeat (8) @(posedge clock_in);
  endtask
  // High cycles of PWM0 and shoot-through cycles over 32 clocks
  task automatic count_high(output logic [7:0] n, output logic [7:0] m);
    n = 8'h00;
    m = 8'h00;
    repeat (32) begin
      @(negedge clock_in);
      n = n + {7'h0, pwm[0]};
      m = m + {7'h0, overlap};
    end
  endtask
  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic t_reset;
    rreg(6'h12, 8'h00, "out_ctl");
    rreg(6'h13, 8'h00, "chan0_csr");
    rreg(6'h21, 8'h03, "csr2");
    rreg(6'h22, 8'h00, "fault");
    rreg(6'h1F, 8'h00, "cap_h");
    wreg(6'h3F, 8'h5A);
    rreg(6'h3F, 8'h00, "unmapped");
    be <= 4'hE;
    wreg(6'h25, 8'h81);
    be <= 4'hF;
    rreg(6'h25, 8'h00, "be_off");
    wreg(6'h22, 8'hC0);
    rreg(6'h22, 8'h00, "fault_top");
    wreg(6'h21, 8'hC3);
    rreg(6'h21, 8'h03, "csr2_top");
  endtask
  task automatic t_capture;
    do_reset();
    wreg(6'h26, 8'h01);
    ticks(5);
    pin_edge(1'b0);
    ticks(3);
    pin_edge(1'b0);
    rreg(6'h20, 8'h05, "cap_first");
    rreg(6'h26, 8'h01, "cap_flag");
    pin_edge(1'b0);
    rreg(6'h20, 8'h08, "cap_again");
    pin_edge(1'b1);
    wreg(6'h21, 8'h23);
    pin_edge(1'b0);
    ticks(2);
    pin_edge(1'b1);
    rreg(6'h20, 8'h0A, "cap_lite");
  endtask
  task automatic t_pwm;
    logic [7:0] n;
    logic [7:0] m;
    do_reset();
    wreg(6'h10, 8'h0F);
    wreg(6'h11, 8'hF0);
    wreg(6'h17, 8'h0F);
    wreg(6'h18, 8'hFC);
    wreg(6'h12, 8'h01);
    wreg(6'h26, 8'h02);
    repeat (4200) @(posedge clock_in);
    chk("pwm_en", 12'h001, {8'h0, pwm_en});
    // High from the reload cycle through the duty match cycle: 13 of 16
    count_high(n, m);
    chk("high_plain", 12'h01A, {4'h0, n});
    rreg(6'h21, 8'h02, "copy1_done");
    rreg(6'h13, 8'h01, "cmp_flag");
    // Guard of one tick: both legs low two cycles after each edge
    wreg(6'h12, 8'h05);
    wreg(6'h25, 8'h81);
    repeat (40) @(posedge clock_in);
    count_high(n, m);
    chk("high_guard", 12'h016, {4'h0, n});
    chk("overlap", 12'h000, {4'h0, m});
    wreg(6'h25, 8'h00);
    wreg(6'h13, 8'h02);
    wreg(6'h21, 8'h03);
    repeat (40) @(posedge clock_in);
    count_high(n, m);
    chk("high_inv", 12'h006, {4'h0, n});
    wreg(6'h22, 8'h1A);
    trip <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk("stop_pat", 12'h00A, {8'h0, pwm});
    rreg(6'h22, 8'h3A, "brk_set");
    trip <= 1'b0;
    wreg(6'h22, 8'h0A);
    trip <= 1'b1;
    repeat (8) @(posedge clock_in);
    rreg(6'h22, 8'h0A, "pin_off");
    trip <= 1'b0;
  endtask
  task automatic t_wrap;
    int n;
    do_reset();
    wreg(6'h23, 8'h08);
    wreg(6'h24, 8'h00);
    wreg(6'h26, 8'h02);
    wreg(6'h21, 8'h14);
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(negedge clock_in);
      n++;
    end
    chk("irq_on", 12'h001, {11'h0, irq});
    rreg(6'h21, 8'h1C, "wrap_set");
    rreg(6'h21, 8'h14, "wrap_clr");
    repeat (3) @(posedge clock_in);
    chk("irq_off", 12'h000, {11'h0, irq});
    wreg(6'h21, 8'h04);
    repeat (2100) @(posedge clock_in);
    chk("irq_masked", 12'h000, {11'h0, irq});
    rreg(6'h21, 8'h0C, "wrap_reload");
  endtask
  // --------------------------------------------------
  // Verdict, watchdog and main sequence
  // --------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge clock_in);
    err_count++;
    finish_test();
  end
  // Runs every scenario
  initial begin
    do_reset();
    t_reset();
    t_capture();
    t_pwm();
    t_wrap();
    finish_test();
  end
endmodule // tb_drtp_timer
